/* File: core/leq_pkg.sv */
/*
 * Types shared by the register bank and the pulse sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package leq_pkg;

  typedef enum logic [1:0] {
    LEQ_EQ_AUTO,
    LEQ_EQ_OFF,
    LEQ_EQ_ONE_STAGE,
    LEQ_EQ_TWO_STAGE
  } leq_eq_mode_t;

  typedef struct packed {
    logic       sign;
    logic [5:0] magnitude;
  } leq_coef_t;

  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [2:0] page;
    logic [4:0] addr;
    logic [7:0] data_in;
  } leq_cpu_t;

  typedef struct packed {
    logic               active;
    logic [1:0]         slot;
    leq_coef_t          coef;
    logic signed [13:0] level_mv;
  } leq_pulse_t;

  typedef struct packed {
    logic            wr_q;
    logic [7:0]      rdata;
    logic            eq_auto_disable;
    logic            eq_single_stage_sel;
    logic            eq_dual_stage_sel;
    leq_eq_mode_t    mode;
    leq_coef_t [3:0] slot;
  } leq_bank_st_t;

endpackage

/* File: core/leq_pulse_seq.sv */
/*
 * Steps the four pulse coefficients over the four sub-intervals of a bit cell.
 * Assumes cell_start is a one-cycle pulse at the start of each cell.
 */
`timescale 1ns/1ps
`include "leq_regs.svh"

module leq_pulse_seq #(
  parameter int SUB_CYCLES = `LEQ_SUB_CYCLES
) (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  // coefficients and timing
  input  wire leq_pkg::leq_coef_t [3:0] coef,
  input  wire logic                    cell_start,
  // to the pulse driver
  output leq_pkg::leq_pulse_t          pulse
);
  import leq_pkg::*;

  typedef enum logic {SEQ_IDLE, SEQ_RUN} leq_seq_state_t;

  typedef struct packed {
    leq_seq_state_t state;
    logic [7:0]     cnt;
    leq_pulse_t     out;
  } leq_seq_st_t;

  leq_seq_st_t st;
  leq_seq_st_t next_st;
  leq_coef_t   sel;

  function automatic logic signed [13:0] leq_level(input leq_coef_t c);
    logic signed [13:0] m;
    m = 14'(c.magnitude) * 14'(`LEQ_MV_PER_STEP);
    return c.sign ? m : -m;
  endfunction

  always_comb begin
    next_st = st;
    sel     = coef[0];
    if (cell_start) begin
      next_st.state  = SEQ_RUN;
      next_st.cnt    = 8'h00;
      next_st.out.slot = 2'h0;
    end else begin
      unique case (st.state)
        SEQ_IDLE: begin
        end
        SEQ_RUN: begin
          if (st.cnt == 8'(SUB_CYCLES - 1)) begin
            next_st.cnt = 8'h00;
            if (st.out.slot == 2'h3)
              next_st.state = SEQ_IDLE;
            else
              next_st.out.slot = st.out.slot + 2'h1;
          end else begin
            next_st.cnt = st.cnt + 8'h01;
          end
        end
      endcase
    end
    next_st.out.active = (next_st.state == SEQ_RUN);
    sel = next_st.out.active ? coef[next_st.out.slot] : '0;
    next_st.out.coef     = sel;
    next_st.out.level_mv = leq_level(sel);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign pulse = st.out;

  AST_LEVEL_SCALE: assert property (@(posedge core_clk) disable iff (!rst_n)
    pulse.level_mv == (pulse.coef.sign ? 14'sd1 : -14'sd1)
                      * $signed({8'h00, pulse.coef.magnitude}) * 14'sd100)
    else $error("pulse level not magnitude times 100 mV");

  AST_SLOT_ORDER: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pulse.active && st.cnt == 8'(SUB_CYCLES - 1) && pulse.slot != 2'h3 && !cell_start)
    |=> pulse.slot == $past(pulse.slot) + 2'h1)
    else $error("pulse slot did not advance in order");

  AST_CELL_FIRST: assert property (@(posedge core_clk) disable iff (!rst_n)
    cell_start |=> (pulse.active && pulse.slot == 2'h0 && pulse.coef == $past(coef[0])))
    else $error("bit cell did not open with the first coefficient");

endmodule // leq_pulse_seq

/* File: core/leq_regbank.sv */
/*
 * Receive equalizer control and custom transmit pulse level registers,
 * written and read over the parallel microprocessor port, page 02H.
 * Assumes port strobes are synchronous to core_clk and held at least two
 * cycles; the analog equalizer and pulse driver sit outside.
 */
// Notes on behaviour
// - Setting the auto-disable bit takes the receive equalizer out of automatic mode.
// - With auto-disable clear the equalizer stays automatic and adapts to line length.
// - Auto-disable and single-stage bits both set select one-stage equalization, about 6 dB.
// - Auto-disable and dual-stage set with single-stage clear select two stages, about 12 dB.
// - Bit 6 of each pulse register is the sign, one positive and zero negative.
// - Bits 5 to 0 of the first pulse register are the unsigned magnitude, bit 5 the MSB.
// - The amplitude is the 6-bit magnitude times 0.1 V.
// - The second pulse register gives the signed level of the second sub-interval.
// - The third pulse register gives the signed level of the third sub-interval.
// - The fourth pulse register gives the signed level of the fourth sub-interval.
// - Reset clears all mode bits and all pulse fields, leaving the equalizer automatic.
`timescale 1ns/1ps
`include "leq_regs.svh"

module leq_regbank #(
  parameter int SUB_CYCLES = `LEQ_SUB_CYCLES
) (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  // parallel microprocessor port
  input  wire leq_pkg::leq_cpu_t       cpu,
  output logic [7:0]                   cpu_data_out,
  output logic                         cpu_data_oe,
  // receive equalizer
  output logic                         eq_auto_disable,
  output logic                         eq_single_stage_sel,
  output logic                         eq_dual_stage_sel,
  output leq_pkg::leq_eq_mode_t        eq_mode,
  // transmit pulse shaping
  input  wire logic                    tx_cell_start,
  output leq_pkg::leq_coef_t [3:0]     pulse_coef,
  output leq_pkg::leq_pulse_t          pulse
);
  import leq_pkg::*;

  leq_bank_st_t st;
  leq_bank_st_t next_st;
  logic         sel;
  logic         wr_act;
  logic         wr_take;
  logic [7:0]   rd_mux;

  function automatic leq_eq_mode_t leq_mode(input logic dis, input logic mid, input logic max);
    if (!dis)
      return LEQ_EQ_AUTO;
    else if (mid)
      return LEQ_EQ_ONE_STAGE;
    else if (max)
      return LEQ_EQ_TWO_STAGE;
    else
      return LEQ_EQ_OFF;
  endfunction

  function automatic logic [7:0] leq_coef_byte(input leq_coef_t c);
    return {1'b0, c};
  endfunction

  assign sel     = !cpu.cs_n && (cpu.page == `LEQ_PAGE);
  assign wr_act  = sel && !cpu.wr_n;
  assign wr_take = wr_act && !st.wr_q;

  always_comb begin
    unique case (cpu.addr)
      `LEQ_OFF_EQ_CTRL: rd_mux = {st.eq_auto_disable, st.eq_single_stage_sel,
                                  st.eq_dual_stage_sel, 5'h00};
      `LEQ_OFF_SLOT1:   rd_mux = leq_coef_byte(st.slot[0]);
      `LEQ_OFF_SLOT2:   rd_mux = leq_coef_byte(st.slot[1]);
      `LEQ_OFF_SLOT3:   rd_mux = leq_coef_byte(st.slot[2]);
      `LEQ_OFF_SLOT4:   rd_mux = leq_coef_byte(st.slot[3]);
      default:          rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    next_st       = st;
    next_st.wr_q  = wr_act;
    next_st.rdata = rd_mux;
    if (wr_take) begin
      unique case (cpu.addr)
        `LEQ_OFF_EQ_CTRL: begin
          next_st.eq_auto_disable     = cpu.data_in[`LEQ_EQ_DIS_BIT];
          next_st.eq_single_stage_sel = cpu.data_in[`LEQ_EQ_MID_BIT];
          next_st.eq_dual_stage_sel   = cpu.data_in[`LEQ_EQ_MAX_BIT];
        end
        `LEQ_OFF_SLOT1: next_st.slot[0] = cpu.data_in[`LEQ_SIGN_BIT:0];
        `LEQ_OFF_SLOT2: next_st.slot[1] = cpu.data_in[`LEQ_SIGN_BIT:0];
        `LEQ_OFF_SLOT3: next_st.slot[2] = cpu.data_in[`LEQ_SIGN_BIT:0];
        `LEQ_OFF_SLOT4: next_st.slot[3] = cpu.data_in[`LEQ_SIGN_BIT:0];
        default: begin
        end
      endcase
    end
    // auto when disable clear, else fixed stage choice
    next_st.mode = leq_mode(next_st.eq_auto_disable, next_st.eq_single_stage_sel,
                            next_st.eq_dual_stage_sel);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st.wr_q                <= 1'b0;
      st.rdata               <= 8'h00;
      {st.eq_auto_disable, st.eq_single_stage_sel, st.eq_dual_stage_sel} <= `LEQ_EQ_RESET;
      st.mode                <= LEQ_EQ_AUTO;
      for (int i = 0; i < 4; i++) begin
        st.slot[i]           <= `LEQ_SLOT_RESET;
      end
    end else begin
      st <= next_st;
    end
  end

  assign cpu_data_out        = st.rdata;
  assign cpu_data_oe         = sel && !cpu.rd_n;
  assign eq_auto_disable     = st.eq_auto_disable;
  assign eq_single_stage_sel = st.eq_single_stage_sel;
  assign eq_dual_stage_sel   = st.eq_dual_stage_sel;
  assign eq_mode             = st.mode;
  assign pulse_coef          = st.slot;

  leq_pulse_seq #(
    .SUB_CYCLES (SUB_CYCLES)
  ) leq_pulse_seq_inst (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .coef       (st.slot),
    .cell_start (tx_cell_start),
    .pulse      (pulse)
  );

  // assertion helpers
  logic after_reset;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      after_reset <= 1'b0;
    else
      after_reset <= 1'b1;
  end

  sequence s_write(logic [4:0] off);
    wr_take && cpu.addr == off;
  endsequence

  AST_DIS_LEAVES_AUTO: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_write(`LEQ_OFF_EQ_CTRL) and cpu.data_in[`LEQ_EQ_DIS_BIT])
    |=> (eq_mode != LEQ_EQ_AUTO && eq_auto_disable))
    else $error("auto-disable write left equalizer automatic");

  AST_AUTO_HELD: assert property (@(posedge core_clk) disable iff (!rst_n)
    !eq_auto_disable |-> eq_mode == LEQ_EQ_AUTO)
    else $error("equalizer not automatic with auto-disable clear");

  AST_ONE_STAGE: assert property (@(posedge core_clk) disable iff (!rst_n)
    (eq_auto_disable && eq_single_stage_sel) |-> eq_mode == LEQ_EQ_ONE_STAGE)
    else $error("one-stage equalization not selected");

  AST_TWO_STAGE: assert property (@(posedge core_clk) disable iff (!rst_n)
    (eq_auto_disable && eq_dual_stage_sel && !eq_single_stage_sel)
    |-> eq_mode == LEQ_EQ_TWO_STAGE)
    else $error("two-stage equalization not selected");

  AST_SLOT1_FIELDS: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_write(`LEQ_OFF_SLOT1) |=> (pulse_coef[0].sign == $past(cpu.data_in[6])
                                 && pulse_coef[0].magnitude == $past(cpu.data_in[5:0])))
    else $error("first pulse register fields wrong");

  AST_SLOT2_FIELDS: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_write(`LEQ_OFF_SLOT2) |=> pulse_coef[1] == $past(cpu.data_in[6:0]))
    else $error("second pulse register fields wrong");

  AST_SLOT3_FIELDS: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_write(`LEQ_OFF_SLOT3) |=> pulse_coef[2] == $past(cpu.data_in[6:0]))
    else $error("third pulse register fields wrong");

  AST_SLOT4_FIELDS: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_write(`LEQ_OFF_SLOT4) |=> (pulse_coef[3] == $past(cpu.data_in[6:0])
                                 && pulse_coef[2] == $past(pulse_coef[2])))
    else $error("fourth pulse register fields wrong");

  AST_RESET_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
    !after_reset |-> (pulse_coef == '0 && eq_mode == LEQ_EQ_AUTO && !eq_auto_disable
                      && !eq_single_stage_sel && !eq_dual_stage_sel))
    else $error("registers not cleared after reset");

  AST_READBACK: assert property (@(posedge core_clk) disable iff (!rst_n)
    (sel && !cpu.rd_n && cpu.addr == `LEQ_OFF_SLOT1 && !wr_act)
    |=> cpu_data_out == {1'b0, $past(pulse_coef[0])})
    else $error("first pulse register read back wrong");

endmodule // leq_regbank

/* File: core/leq_regs.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * line equalizer and pulse shape register bank.
 * Assumes a 5-bit register address and an 8-bit data path on page 02H.
 */
`ifndef LEQ_REGS_SVH
`define LEQ_REGS_SVH

`define LEQ_PAGE           3'h2
`define LEQ_OFF_EQ_CTRL    5'h19
`define LEQ_OFF_SLOT1      5'h1C
`define LEQ_OFF_SLOT2      5'h1D
`define LEQ_OFF_SLOT3      5'h1E
`define LEQ_OFF_SLOT4      5'h1F

`define LEQ_EQ_DIS_BIT     7
`define LEQ_EQ_MID_BIT     6
`define LEQ_EQ_MAX_BIT     5
`define LEQ_SIGN_BIT       6
`define LEQ_MAG_MSB        5

`define LEQ_EQ_RESET       3'h0
`define LEQ_SLOT_RESET     7'h00

`define LEQ_MV_PER_STEP    100
`define LEQ_CLK_PERIOD_NS  25
`define LEQ_CELL_NS        488
`define LEQ_SUB_CYCLES     ((`LEQ_CELL_NS / 4) / `LEQ_CLK_PERIOD_NS)

`endif

/* File: dv/leq_host_model.sv */
/* host on the parallel register port: byte writes and reads.
   assumes the bank takes a write on strobe assertion and answers reads a cycle later. */
`timescale 1ns/1ps
module leq_host_model (
  // clock
  input  wire logic        core_clk,
  // register port
  output leq_pkg::leq_cpu_t cpu,
  input  wire logic [7:0]  cpu_data_out,
  input  wire logic        cpu_data_oe
);
  import leq_pkg::*;
  initial cpu = '{1'b1, 1'b1, 1'b1, 3'h0, 5'h00, 8'h00};

  // strobe held two edges; released data bus shows the inverse
  task automatic wr(input logic [2:0] pg, input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    cpu <= '{1'b0, 1'b1, 1'b0, pg, a, d};
    repeat (2) @(posedge core_clk);
    cpu <= '{1'b1, 1'b1, 1'b1, pg, a, ~d};
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic oe);
    @(posedge core_clk);
    cpu <= '{1'b0, 1'b0, 1'b1, 3'h2, a, ~cpu.data_in};
    repeat (2) @(posedge core_clk);
    d = cpu_data_out;
    oe = cpu_data_oe;
    cpu <= '{1'b1, 1'b1, 1'b1, 3'h2, a, ~cpu.data_in};
  endtask
endmodule // leq_host_model

/* File: dv/test_leq_regbank.sv */
/* self-checking bench of the equalizer and pulse level register bank.
   assumes the host model drives the port and the cell pulse comes from here. */
`timescale 1ns/1ps
module test_leq_regbank;
  import leq_pkg::*;
  localparam int SUB = 2;
  logic            core_clk = 1'b0;
  logic            rst_n = 1'b0;
  logic            tx_cell_start = 1'b0;
  leq_cpu_t        cpu;
  logic [7:0]      cpu_data_out;
  logic            cpu_data_oe;
  logic            eq_auto_disable;
  logic            eq_single_stage_sel;
  logic            eq_dual_stage_sel;
  leq_eq_mode_t    eq_mode;
  leq_coef_t [3:0] pulse_coef;
  leq_pulse_t      pulse;
  logic [7:0]      sv [4] = '{8'hC5, 8'h3F, 8'h40, 8'hFF};
  int              n_fail = 0;
  int              checks = 0;

  leq_regbank #(.SUB_CYCLES(SUB)) leq_regbank_inst (.core_clk(core_clk), .rst_n(rst_n),
    .cpu(cpu), .cpu_data_out(cpu_data_out), .cpu_data_oe(cpu_data_oe),
    .eq_auto_disable(eq_auto_disable), .eq_single_stage_sel(eq_single_stage_sel),
    .eq_dual_stage_sel(eq_dual_stage_sel), .eq_mode(eq_mode),
    .tx_cell_start(tx_cell_start), .pulse_coef(pulse_coef), .pulse(pulse));
  leq_host_model leq_host_model_inst (.core_clk(core_clk), .cpu(cpu),
    .cpu_data_out(cpu_data_out), .cpu_data_oe(cpu_data_oe));

  initial forever #12.5 core_clk = ~core_clk;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic t_reset_values;
    logic [7:0] d;
    logic       oe;
    chk("eq_mode", eq_mode, LEQ_EQ_AUTO);
    chk("eq_bits", {eq_auto_disable, eq_single_stage_sel, eq_dual_stage_sel}, 0);
    chk("pulse_coef", 32'(pulse_coef), 0);
    chk("pulse", 32'(pulse), 0);
    foreach (sv[i]) begin
      leq_host_model_inst.rd(5'h1C + 5'(i), d, oe);
      chk("reset_read", d, 0);
    end
  endtask

  task automatic t_eq_modes;
    logic [7:0]   wv [6] = '{8'h00, 8'h80, 8'hC0, 8'hBF, 8'hFF, 8'h60};
    leq_eq_mode_t m;
    logic [7:0]   d;
    logic         oe;
    foreach (wv[i]) begin
      leq_host_model_inst.wr(3'h2, 5'h19, wv[i]);
      @(posedge core_clk);
      #1;
      m = !wv[i][7] ? LEQ_EQ_AUTO : wv[i][6] ? LEQ_EQ_ONE_STAGE :
          wv[i][5] ? LEQ_EQ_TWO_STAGE : LEQ_EQ_OFF;
      chk("eq_mode", eq_mode, m);
      chk("eq_bits", {eq_auto_disable, eq_single_stage_sel, eq_dual_stage_sel}, wv[i][7:5]);
      leq_host_model_inst.rd(5'h19, d, oe);
      chk("eq_read", d, wv[i] & 8'hE0);
      chk("read_oe", oe, 1);
    end
  endtask

  task automatic t_slots;
    logic [7:0] d;
    logic       oe;
    foreach (sv[i]) leq_host_model_inst.wr(3'h2, 5'h1C + 5'(i), sv[i]);
    leq_host_model_inst.wr(3'h3, 5'h1C, 8'h11);
    leq_host_model_inst.wr(3'h2, 5'h1A, 8'h55);
    @(posedge core_clk);
    #1;
    foreach (sv[i]) begin
      chk("slot_coef", pulse_coef[i], sv[i][6:0]);
      leq_host_model_inst.rd(5'h1C + 5'(i), d, oe);
      chk("slot_read", d, sv[i] & 8'h7F);
    end
    leq_host_model_inst.rd(5'h1A, d, oe);
    chk("unmapped_read", d, 0);
  endtask

  task automatic t_pulse;
    logic signed [13:0] lv;
    int                 s;
    @(posedge core_clk);
    tx_cell_start <= 1'b1;
    @(posedge core_clk);
    tx_cell_start <= 1'b0;
    for (int k = 0; k < 4 * SUB; k++) begin
      #1;
      s = k / SUB;
      lv = sv[s][6] ? 14'(int'(sv[s][5:0]) * 100) : 14'(-int'(sv[s][5:0]) * 100);
      chk("pulse_active", pulse.active, 1);
      chk("pulse_slot", pulse.slot, s);
      chk("pulse_coef", pulse.coef, sv[s][6:0]);
      chk("pulse_level", pulse.level_mv, lv);
      @(posedge core_clk);
    end
    #1;
    chk("pulse_idle", pulse.active, 0);
    chk("pulse_idle_level", pulse.level_mv, 0);
  endtask

  task automatic t_mid_reset;
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    t_reset_values;
  endtask

  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    report_and_stop;
  end

  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    t_reset_values;
    t_eq_modes;
    t_slots;
    t_pulse;
    t_mid_reset;
    report_and_stop;
  end
endmodule // test_leq_regbank
